/* File: rtl/pwc_defines.svh */
`ifndef PWC_DEFINES_SVH
`define PWC_DEFINES_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define PWC_IDX_CLOCK_SELECT 6'h05
`define PWC_IDX_PLL_CONTROL 6'h06
`define PWC_IDX_AUX_CONTROL 6'h0B
`define PWC_IDX_STATUS 6'h0C

// ****************************************
// Clock select fields
// ****************************************
`define PWC_CS_CORE_WAIT 2
`define PWC_CS_TICK_WAIT 1
`define PWC_CS_WDOG_WAIT 0

// ****************************************
// PLL control fields
// ****************************************
`define PWC_PC_MON_EN 7
`define PWC_PC_POWER 6
`define PWC_PC_AUTO_BW 5
`define PWC_PC_MANUAL_BW 4
`define PWC_PC_SPARE 3
`define PWC_PC_TICK_PSTOP 2
`define PWC_PC_WDOG_PSTOP 1
`define PWC_PC_SC_EN 0

// ****************************************
// Auxiliary control and status fields
// ****************************************
`define PWC_AUX_PLL_WAIT 0
`define PWC_AUX_PSTOP 1
`define PWC_AUX_PLL_SEL 2
`define PWC_ST_SELFCLOCK 0
`define PWC_ST_WAIT 1
`define PWC_ST_STOP 2
`define PWC_ST_BW_HIGH 3

// ****************************************
// Reset values
// ****************************************
`define PWC_RST_CLOCK_SELECT 8'h00
`define PWC_RST_PLL_CONTROL 8'h00
`define PWC_RST_AUX 3'h0

`endif

/* File: rtl/pwc_pkg.sv */
// ****************************************
// Types shared by the clock control block
// ****************************************
package pwc_pkg;

	// Power mode of the part as seen by the clock logic.
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_WAIT,
		MODE_STOP
	} mode_t;

	// Whole state of the block, registered in one place.
	typedef struct packed {
		mode_t mode;
		logic [7:0] clock_sel;
		logic [7:0] pll_ctl;
		logic [2:0] aux;
		logic wdog_once;
		logic sc_once;
		logic selfclock;
		logic [2:0] sync_special;
		logic [2:0] sync_fail;
		logic [2:0] sync_near;
		logic special;
		logic fail;
		logic near;
		logic ack;
		logic [31:0] rdata;
		logic core_clk_en;
		logic tick_run;
		logic tick_clear;
		logic wdog_run;
		logic wdog_clear;
		logic mon_active;
		logic pll_on;
		logic bw_high;
		logic osc_on;
		logic osc_low_amp;
		logic mon_reset;
	} ctl_state_t;

endpackage

/* File: rtl/pll_and_wait_clock_control.sv */
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "pwc_defines.svh"

// How it works
// - Core clock gated in wait when set.
// - Tick stops, dividers cleared on wait entry.
// - Watchdog stops in wait; write once normally.
// - Monitor enable write ignored in self-clock.
// - Enabled monitor reacts to failed oscillator.
// - Full stop disables the clock monitor.
// - PLL power write ignored when PLL selected.
// - Self-clock mode forces PLL power on.
// - Powered PLL with auto bandwidth locks itself.
// - Auto picks bandwidth; manual bit otherwise.
// - PLL wait stop forces auto bandwidth.
// - Manual bit selects filter when auto off.
// - Tick runs in pseudo-stop when enabled.
// - Tick dividers frozen, not cleared, pseudo-stop.
// - Watchdog runs in pseudo-stop when enabled.
// - Watchdog dividers frozen in pseudo-stop.
// - Self-clock enable write once, sticky.
// - Failure gives reset or self-clock mode.
// - Status shows self-clock mode.
// - Pseudo-stop keeps oscillator at low amplitude.
module pll_and_wait_clock_control (
	input wire logic clk_sys, // Bus clock.
	input wire logic arst_n, // Asynchronous reset, low.
	input wire logic wb_cyc, // Wishbone cycle.
	input wire logic wb_stb, // Wishbone strobe.
	input wire logic wb_we, // Wishbone write enable.
	input wire logic [7:0] wb_adr, // Wishbone byte address.
	input wire logic [3:0] wb_sel, // Wishbone byte selects.
	input wire logic [31:0] wb_dat_w, // Wishbone write data.
	output logic [31:0] wb_dat_r, // Wishbone read data.
	output logic wb_ack, // Wishbone acknowledge.
	input wire logic special_mode, // Special mode strap, async.
	input wire logic wait_req, // Core requests wait mode.
	input wire logic stop_req, // Core requests stop mode.
	input wire logic osc_fail, // Monitor sees lost clock, async.
	input wire logic pll_near, // VCO near target, async.
	output logic core_clk_en, // Core clock enable.
	output logic tick_run, // Periodic tick timer runs.
	output logic tick_clear, // Tick divider clear pulse.
	output logic wdog_run, // Watchdog runs.
	output logic wdog_clear, // Watchdog divider clear pulse.
	output logic mon_active, // Clock monitor active.
	output logic pll_on, // PLL analog power.
	output logic bw_high, // High bandwidth filter.
	output logic osc_on, // Oscillator enable.
	output logic osc_low_amp, // Reduced oscillator amplitude.
	output logic mon_reset, // Clock monitor reset request.
	output logic selfclock_status // Running in self-clock mode.
);

	// ****************************************
	// Helpers
	// ****************************************

	// Address decode for one register index.
	function automatic logic hit(input logic [7:0] adr,
		input logic [5:0] idx);
		hit = (adr[7:2] == idx);
	endfunction

	// Pin filter: take the new level once stages two and three agree.
	function automatic logic filt(input logic [2:0] s,
		input logic old);
		filt = (s[1] == s[2]) ? s[2] : old;
	endfunction

	pwc_pkg::ctl_state_t q;
	pwc_pkg::ctl_state_t n;
	logic req;
	logic wr;
	logic wr_cs;
	logic wr_pc;
	logic wr_aux;
	logic enter_wait;
	logic enter_stop;
	logic pstop;
	logic full_stop;
	logic auto_bw;
	logic [7:0] wd;

	// ****************************************
	// Next state
	// ****************************************

	// Bus decode; writes land on the edge where the master sees ack.
	always_comb begin
		req = wb_cyc & wb_stb;
		wr = req & wb_we & q.ack & wb_sel[0];
		wr_cs = wr & hit(wb_adr, `PWC_IDX_CLOCK_SELECT);
		wr_pc = wr & hit(wb_adr, `PWC_IDX_PLL_CONTROL);
		wr_aux = wr & hit(wb_adr, `PWC_IDX_AUX_CONTROL);
		wd = wb_dat_w[7:0];
	end

	// All state updates in one place.
	always_comb begin
		n = q;
		// Outside pins pass three stages before use.
		n.sync_special = {q.sync_special[1:0], special_mode};
		n.sync_fail = {q.sync_fail[1:0], osc_fail};
		n.sync_near = {q.sync_near[1:0], pll_near};
		n.special = filt(q.sync_special, q.special);
		n.fail = filt(q.sync_fail, q.fail);
		n.near = filt(q.sync_near, q.near);

		// Stop has priority over wait.
		if (stop_req) begin
			n.mode = pwc_pkg::MODE_STOP;
		end else if (wait_req) begin
			n.mode = pwc_pkg::MODE_WAIT;
		end else begin
			n.mode = pwc_pkg::MODE_RUN;
		end
		enter_wait = (n.mode == pwc_pkg::MODE_WAIT) &&
			(q.mode != pwc_pkg::MODE_WAIT);
		enter_stop = (n.mode == pwc_pkg::MODE_STOP) &&
			(q.mode != pwc_pkg::MODE_STOP);

		// Clock select: core and tick bits are free to write.
		if (wr_cs) begin
			n.clock_sel[`PWC_CS_CORE_WAIT] = wd[`PWC_CS_CORE_WAIT];
			n.clock_sel[`PWC_CS_TICK_WAIT] = wd[`PWC_CS_TICK_WAIT];
			if (q.special || !q.wdog_once) begin
				n.clock_sel[`PWC_CS_WDOG_WAIT] =
					wd[`PWC_CS_WDOG_WAIT];
			end
			if (!q.special) begin
				n.wdog_once = 1'b1;
			end
		end

		// Auxiliary bits stand in for the upper select bits.
		if (wr_aux) begin
			n.aux = wd[2:0];
		end

		// PLL control writes; monitor enable, power and self-clock enable bits have guards.
		if (wr_pc) begin
			if (!q.selfclock) begin
				n.pll_ctl[`PWC_PC_MON_EN] = wd[`PWC_PC_MON_EN];
			end
			if (!q.aux[`PWC_AUX_PLL_SEL]) begin
				n.pll_ctl[`PWC_PC_POWER] = wd[`PWC_PC_POWER];
			end
			n.pll_ctl[`PWC_PC_AUTO_BW] = wd[`PWC_PC_AUTO_BW];
			n.pll_ctl[`PWC_PC_MANUAL_BW] = wd[`PWC_PC_MANUAL_BW];
			n.pll_ctl[`PWC_PC_TICK_PSTOP] = wd[`PWC_PC_TICK_PSTOP];
			n.pll_ctl[`PWC_PC_WDOG_PSTOP] = wd[`PWC_PC_WDOG_PSTOP];
			// write once, no clear in self-clock
			if (q.special || !q.sc_once) begin
				n.pll_ctl[`PWC_PC_SC_EN] = wd[`PWC_PC_SC_EN] |
					(q.selfclock & q.pll_ctl[`PWC_PC_SC_EN]);
			end
			if (!q.special) begin
				n.sc_once = 1'b1;
			end
		end
		n.pll_ctl[`PWC_PC_SPARE] = 1'b0;
		if (q.aux[`PWC_AUX_PLL_WAIT]) begin
			n.pll_ctl[`PWC_PC_AUTO_BW] = 1'b1;
		end

		pstop = n.aux[`PWC_AUX_PSTOP];
		full_stop = (n.mode == pwc_pkg::MODE_STOP) && !pstop;

		n.mon_active = n.pll_ctl[`PWC_PC_MON_EN] && !full_stop;

		// failure response; mode exits when clock returns.
		n.mon_reset = 1'b0;
		if (q.mon_active && n.fail && !q.selfclock) begin
			if (q.pll_ctl[`PWC_PC_SC_EN]) begin
				n.selfclock = 1'b1;
			end else begin
				n.mon_reset = 1'b1;
			end
		end else if (!n.fail) begin
			n.selfclock = 1'b0;
		end

		// The PLL is deselected on the same edge where it can lose power or lock.
		if ((n.selfclock && !q.selfclock) || enter_stop ||
			(enter_wait && n.aux[`PWC_AUX_PLL_WAIT])) begin
			n.aux[`PWC_AUX_PLL_SEL] = 1'b0;
		end

		n.core_clk_en = !((n.mode == pwc_pkg::MODE_WAIT) &&
			n.clock_sel[`PWC_CS_CORE_WAIT]);

		n.tick_run = !(((n.mode == pwc_pkg::MODE_WAIT) &&
			n.clock_sel[`PWC_CS_TICK_WAIT]) ||
			((n.mode == pwc_pkg::MODE_STOP) &&
			!(pstop && n.pll_ctl[`PWC_PC_TICK_PSTOP])));
		n.tick_clear = enter_wait && n.clock_sel[`PWC_CS_TICK_WAIT];

		n.wdog_run = !(((n.mode == pwc_pkg::MODE_WAIT) &&
			n.clock_sel[`PWC_CS_WDOG_WAIT]) ||
			((n.mode == pwc_pkg::MODE_STOP) &&
			!(pstop && n.pll_ctl[`PWC_PC_WDOG_PSTOP])));
		n.wdog_clear = enter_wait && n.clock_sel[`PWC_CS_WDOG_WAIT];

		// PLL power; wait with PLL wait stop powers it down.
		n.pll_on = n.selfclock || (n.pll_ctl[`PWC_PC_POWER] &&
			!((n.mode == pwc_pkg::MODE_WAIT) &&
			n.aux[`PWC_AUX_PLL_WAIT]));

		auto_bw = n.pll_ctl[`PWC_PC_AUTO_BW];
		n.bw_high = auto_bw ? !n.near :
			n.pll_ctl[`PWC_PC_MANUAL_BW];

		n.osc_on = !full_stop;
		n.osc_low_amp = (n.mode == pwc_pkg::MODE_STOP) && pstop;

		// Single-cycle classic answer; unmapped reads give zero.
		n.ack = req && !q.ack;
		n.rdata = 32'h0000_0000;
		if (req && !q.ack && !wb_we) begin
			if (hit(wb_adr, `PWC_IDX_CLOCK_SELECT)) begin
				n.rdata[2:0] = q.clock_sel[2:0];
			end else if (hit(wb_adr, `PWC_IDX_PLL_CONTROL)) begin
				n.rdata[7:0] = q.pll_ctl;
			end else if (hit(wb_adr, `PWC_IDX_AUX_CONTROL)) begin
				n.rdata[2:0] = q.aux;
			end else if (hit(wb_adr, `PWC_IDX_STATUS)) begin
				n.rdata[`PWC_ST_SELFCLOCK] = q.selfclock;
				n.rdata[`PWC_ST_WAIT] = (q.mode == pwc_pkg::MODE_WAIT);
				n.rdata[`PWC_ST_STOP] = (q.mode == pwc_pkg::MODE_STOP);
				n.rdata[`PWC_ST_BW_HIGH] = q.bw_high;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************

	// Reset loads zero; the run-state outputs come up one edge later.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from the state register.
	always_comb begin
		wb_dat_r = q.rdata;
		wb_ack = q.ack;
		core_clk_en = q.core_clk_en;
		tick_run = q.tick_run;
		tick_clear = q.tick_clear;
		wdog_run = q.wdog_run;
		wdog_clear = q.wdog_clear;
		mon_active = q.mon_active;
		pll_on = q.pll_on;
		bw_high = q.bw_high;
		osc_on = q.osc_on;
		osc_low_amp = q.osc_low_amp;
		mon_reset = q.mon_reset;
		selfclock_status = q.selfclock;
	end

	// ****************************************
	// Assertions
	// ****************************************

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	property p_core_stop;
		q.clock_sel[`PWC_CS_CORE_WAIT] && wait_req && !stop_req
			&& !wr_cs |=> !core_clk_en;
	endproperty
	a_core_stop: assert property (p_core_stop)
		else $error("core clock runs in wait with gate set");

	property p_tick_clear;
		$rose(q.mode == pwc_pkg::MODE_WAIT) &&
			q.clock_sel[`PWC_CS_TICK_WAIT] |-> tick_clear && !tick_run
			##1 !tick_clear;
	endproperty
	a_tick_clear: assert property (p_tick_clear)
		else $error("tick clear not a single pulse at wait entry");

	property p_wdog_once;
		!q.special && !n.special && q.wdog_once && wr_cs
			|=> $stable(q.clock_sel[`PWC_CS_WDOG_WAIT]);
	endproperty
	a_wdog_once: assert property (p_wdog_once)
		else $error("watchdog wait bit written twice");

	property p_mon_guard;
		q.selfclock && wr_pc |=> $stable(q.pll_ctl[`PWC_PC_MON_EN]);
	endproperty
	a_mon_guard: assert property (p_mon_guard)
		else $error("monitor enable changed in self-clock mode");

	property p_full_stop;
		(q.mode == pwc_pkg::MODE_STOP) && !q.aux[`PWC_AUX_PSTOP]
			|-> !mon_active && !osc_on;
	endproperty
	a_full_stop: assert property (p_full_stop)
		else $error("monitor or oscillator on in full stop");

	property p_power_guard;
		q.aux[`PWC_AUX_PLL_SEL] && wr_pc
			|=> $stable(q.pll_ctl[`PWC_PC_POWER]);
	endproperty
	a_power_guard: assert property (p_power_guard)
		else $error("pll power changed while pll selected");

	property p_sc_power;
		q.selfclock |-> pll_on;
	endproperty
	a_sc_power: assert property (p_sc_power)
		else $error("pll off in self-clock mode");

	property p_force_auto;
		q.aux[`PWC_AUX_PLL_WAIT] |=> q.pll_ctl[`PWC_PC_AUTO_BW];
	endproperty
	a_force_auto: assert property (p_force_auto)
		else $error("auto bandwidth not forced");

	property p_manual_bw;
		!q.pll_ctl[`PWC_PC_AUTO_BW] |-> bw_high ==
			q.pll_ctl[`PWC_PC_MANUAL_BW];
	endproperty
	a_manual_bw: assert property (p_manual_bw)
		else $error("filter does not follow manual bit");

	property p_tick_freeze;
		(q.mode == pwc_pkg::MODE_STOP) && q.aux[`PWC_AUX_PSTOP] &&
			!q.pll_ctl[`PWC_PC_TICK_PSTOP] |-> !tick_run && !tick_clear;
	endproperty
	a_tick_freeze: assert property (p_tick_freeze)
		else $error("tick not frozen in pseudo-stop");

	property p_sc_sticky;
		q.selfclock && q.pll_ctl[`PWC_PC_SC_EN]
			|=> q.pll_ctl[`PWC_PC_SC_EN];
	endproperty
	a_sc_sticky: assert property (p_sc_sticky)
		else $error("self-clock enable cleared in self-clock mode");

	property p_fail_reset;
		q.mon_active && n.fail && !q.selfclock &&
			!q.pll_ctl[`PWC_PC_SC_EN] |=> mon_reset && !selfclock_status;
	endproperty
	a_fail_reset: assert property (p_fail_reset)
		else $error("no monitor reset on clock failure");

	property p_spare_zero;
		wb_ack |-> wb_dat_r[`PWC_PC_SPARE] == 1'b0 ||
			!$past(hit(wb_adr, `PWC_IDX_PLL_CONTROL));
	endproperty
	a_spare_zero: assert property (p_spare_zero)
		else $error("spare control bit reads one");

	c_wait_entry: cover property (tick_clear ##1 !core_clk_en);
	c_selfclock: cover property ($rose(selfclock_status));
	c_mon_reset: cover property ($rose(mon_reset));
	c_pstop: cover property (osc_low_amp && tick_run);

endmodule

/* File: dv/pll_and_wait_clock_control_test.sv */
`timescale 1ns/1ps

// ****************************************
// Register level test of the clock control
// ****************************************
module pll_and_wait_clock_control_test;

	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h00000000;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic special_mode = 1'b0;
	logic wait_req = 1'b0;
	logic stop_req = 1'b0;
	logic osc_fail = 1'b0;
	logic pll_near = 1'b0;
	logic core_clk_en, tick_run, tick_clear, wdog_run, wdog_clear;
	logic mon_active, pll_on, bw_high, osc_on, osc_low_amp;
	logic mon_reset, selfclock_status;
	int error_cnt = 0;
	int tests_run = 0;

	// A 200 MHz clock, 5 ns period.
	always begin
		#2.5 clk_sys = ~clk_sys;
	end

	pll_and_wait_clock_control pll_and_wait_clock_control_inst (
		.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc(wb_cyc),
		.wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack), .special_mode(special_mode),
		.wait_req(wait_req), .stop_req(stop_req), .osc_fail(osc_fail),
		.pll_near(pll_near), .core_clk_en(core_clk_en),
		.tick_run(tick_run), .tick_clear(tick_clear),
		.wdog_run(wdog_run), .wdog_clear(wdog_clear),
		.mon_active(mon_active), .pll_on(pll_on), .bw_high(bw_high),
		.osc_on(osc_on), .osc_low_amp(osc_low_amp),
		.mon_reset(mon_reset), .selfclock_status(selfclock_status)
	);

	// ****************************************
	// Reporting
	// ****************************************

	// The single place where the run ends.
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t register read %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string nm);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s is %b, wanted %b", $time, nm, got, exp);
		end
	endtask

	// ****************************************
	// Bus and pin helpers
	// ****************************************

	// One classic cycle; the bound keeps a dead slave from hanging us.
	task automatic bus(input logic we, input logic [7:0] adr,
			input logic [7:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hF;
		wb_dat_w <= {24'h000000, wd};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t no acknowledge", $time);
			finish_test();
		end
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
		logic [31:0] dummy;
		bus(1'b1, adr, wd, dummy);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
		logic [31:0] got;
		bus(1'b0, adr, 8'h00, got);
		chk_reg(got, {24'h000000, exp});
	endtask

	// Waits whole cycles, then steps past the edge so outputs are settled.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Filtered inputs and the outputs built from them settle within four edges.
	localparam int SYNC_WAIT = 8;

	// Global guard against a hang anywhere in the sequence.
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		$display("BAD %0t run took too long", $time);
		finish_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		// Reset values and an unmapped word that must read zero.
		rd(8'h14, 8'h00);
		rd(8'h18, 8'h00);
		rd(8'h2C, 8'h00);
		wr(8'h3C, 8'hFF);
		rd(8'h3C, 8'h00);
		// Write-once bits in normal mode, spare bit reads zero.
		wr(8'h14, 8'h07);
		rd(8'h14, 8'h07);
		wr(8'h14, 8'h06);
		rd(8'h14, 8'h07);
		wr(8'h18, 8'h09);
		rd(8'h18, 8'h01);
		wr(8'h18, 8'h00);
		rd(8'h18, 8'h01);
		// Wait entry with all three stop bits set.
		// The clear pulses stand one cycle, so look right after they rise.
		@(posedge clk_sys);
		wait_req <= 1'b1;
		tick(1);
		chk_bit(core_clk_en, 1'b0, "core_clk_en");
		chk_bit(tick_run, 1'b0, "tick_run");
		chk_bit(tick_clear, 1'b1, "tick_clear");
		chk_bit(wdog_run, 1'b0, "wdog_run");
		chk_bit(wdog_clear, 1'b1, "wdog_clear");
		tick(1);
		chk_bit(tick_clear, 1'b0, "tick_clear");
		rd(8'h30, 8'h02);
		wait_req <= 1'b0;
		tick(2);
		chk_bit(core_clk_en, 1'b1, "core_clk_en");
		// Wait entry with only the locked watchdog bit left.
		wr(8'h14, 8'h00);
		rd(8'h14, 8'h01);
		@(posedge clk_sys);
		wait_req <= 1'b1;
		tick(1);
		chk_bit(core_clk_en, 1'b1, "core_clk_en");
		chk_bit(tick_run, 1'b1, "tick_run");
		chk_bit(tick_clear, 1'b0, "tick_clear");
		chk_bit(wdog_run, 1'b0, "wdog_run");
		chk_bit(wdog_clear, 1'b1, "wdog_clear");
		// Pins move only on a rising edge, never between them.
		@(posedge clk_sys);
		wait_req <= 1'b0;
		// Power and manual bandwidth.
		wr(8'h18, 8'h40);
		tick(2);
		chk_bit(pll_on, 1'b1, "pll_on");
		chk_bit(bw_high, 1'b0, "bw_high");
		wr(8'h18, 8'h50);
		tick(2);
		chk_bit(bw_high, 1'b1, "bw_high");
		// Automatic bandwidth follows the near-target input.
		wr(8'h18, 8'h60);
		tick(SYNC_WAIT);
		chk_bit(bw_high, 1'b1, "bw_high");
		@(posedge clk_sys);
		pll_near <= 1'b1;
		tick(SYNC_WAIT);
		chk_bit(bw_high, 1'b0, "bw_high");
		@(posedge clk_sys);
		pll_near <= 1'b0;
		// Power bit is guarded while the PLL clock is selected.
		wr(8'h2C, 8'h04);
		rd(8'h2C, 8'h04);
		wr(8'h18, 8'h21);
		rd(8'h18, 8'h61);
		tick(1);
		chk_bit(pll_on, 1'b1, "pll_on");
		// Wait-stop forces automatic bandwidth.
		wr(8'h2C, 8'h01);
		wr(8'h18, 8'h00);
		rd(8'h18, 8'h21);
		// Pseudo-stop: oscillator low, tick runs, watchdog frozen.
		wr(8'h2C, 8'h02);
		wr(8'h18, 8'h85);
		rd(8'h18, 8'h85);
		tick(2);
		chk_bit(mon_active, 1'b1, "mon_active");
		@(posedge clk_sys);
		stop_req <= 1'b1;
		tick(2);
		chk_bit(osc_on, 1'b1, "osc_on");
		chk_bit(osc_low_amp, 1'b1, "osc_low_amp");
		chk_bit(mon_active, 1'b1, "mon_active");
		chk_bit(tick_run, 1'b1, "tick_run");
		chk_bit(wdog_run, 1'b0, "wdog_run");
		chk_bit(tick_clear, 1'b0, "tick_clear");
		chk_bit(wdog_clear, 1'b0, "wdog_clear");
		@(posedge clk_sys);
		stop_req <= 1'b0;
		// Full stop shuts the oscillator and the monitor.
		wr(8'h2C, 8'h00);
		@(posedge clk_sys);
		stop_req <= 1'b1;
		tick(2);
		chk_bit(osc_on, 1'b0, "osc_on");
		chk_bit(mon_active, 1'b0, "mon_active");
		chk_bit(tick_run, 1'b0, "tick_run");
		@(posedge clk_sys);
		stop_req <= 1'b0;
		tick(2);
		chk_bit(mon_active, 1'b1, "mon_active");
		// Oscillator failure with self-clock enabled.
		@(posedge clk_sys);
		osc_fail <= 1'b1;
		tick(SYNC_WAIT);
		chk_bit(selfclock_status, 1'b1, "selfclock_status");
		chk_bit(mon_reset, 1'b0, "mon_reset");
		chk_bit(pll_on, 1'b1, "pll_on");
		rd(8'h30, 8'h01);
		wr(8'h18, 8'h04);
		rd(8'h18, 8'h85);
		osc_fail <= 1'b0;
		tick(SYNC_WAIT);
		chk_bit(selfclock_status, 1'b0, "selfclock_status");
		chk_bit(pll_on, 1'b0, "pll_on");
		// Special mode: write-once bits may change again.
		@(posedge clk_sys);
		special_mode <= 1'b1;
		tick(SYNC_WAIT);
		wr(8'h18, 8'h80);
		rd(8'h18, 8'h80);
		wr(8'h14, 8'h00);
		rd(8'h14, 8'h00);
		// Failure without self-clock gives a monitor reset.
		osc_fail <= 1'b1;
		tick(SYNC_WAIT);
		chk_bit(mon_reset, 1'b1, "mon_reset");
		chk_bit(selfclock_status, 1'b0, "selfclock_status");
		@(posedge clk_sys);
		osc_fail <= 1'b0;
		tick(SYNC_WAIT);
		chk_bit(mon_reset, 1'b0, "mon_reset");
		finish_test();
	end

endmodule
